// ---- scdc_clock_ctrl.sv ----
// scdc_clock_ctrl: divider registers, slow oscillator control and the
// stabilization wait timer after stop release.
// assumes: cpu register port on sys_clk_i, option byte levels stable
// from logic on the same clock, osc_started_i from a pin.
//
// Functional notes
// - reset loads cpu divider and prescaler 0x02
// - cpu clock ratio from three bits encoded
// - prescaler 0x01 gives peripheral clock fx/2
// - prescaler 0x02 gives peripheral clock fx/4
// - divider and slow osc take bit writes
// - reset clears slow osc control to zero
// - bit 0 set stops slow oscillator
// - option forbids stop: halt bit ignored
// - forbidden stop fixes watchdog to slow osc
// - wait select gives 2^10/12/15/17 periods
// - wait only for crystal after stop release
// - wait counts after oscillation has started
// - wait select takes byte writes only
// - power-on source from option; no power-on wait, reset enters run
// - option byte picks one of three sources
// - stop instruction halts active system source
`timescale 1ns/10ps
module scdc_clock_ctrl
    import scdc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // cpu register port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_bit_wr_i,
    input  wire logic [2:0]  reg_bit_sel_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // option byte and power state
    input  wire logic [1:0]  opt_clk_src_i,
    input  wire logic        opt_slow_stop_ok_i,
    input  wire logic        stop_exec_i,
    input  wire logic        stop_release_i,
    input  wire logic        osc_started_i,
    // clock control outputs
    output logic             cpu_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             cpu_clk_bad_o,
    output logic             hs_int_osc_en_o,
    output logic             crystal_osc_en_o,
    output logic             ext_clk_en_o,
    output logic             slow_osc_en_o,
    output logic             wdt_src_fixed_o,
    output logic             stab_wait_o
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] cpu_div_reg,  cpu_div_next;
    logic [7:0] prescale_reg, prescale_next;
    logic [7:0] slow_osc_reg, slow_osc_next;
    logic [7:0] wait_sel_reg, wait_sel_next;
    logic [7:0] bit_mask;

    always_comb begin
        bit_mask      = 8'h01 << reg_bit_sel_i;
        cpu_div_next  = cpu_div_reg;
        prescale_next = prescale_reg;
        slow_osc_next = slow_osc_reg;
        wait_sel_next = wait_sel_reg;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                SCDC_ADDR_CPU_DIV:  cpu_div_next  = reg_wdata_i & SCDC_CPU_DIV_MASK;
                SCDC_ADDR_PRESCALE: prescale_next = reg_wdata_i & SCDC_PRESCALE_MASK;
                SCDC_ADDR_SLOW_OSC: slow_osc_next = reg_wdata_i & SCDC_SLOW_OSC_MASK;
                SCDC_ADDR_WAIT_SEL: wait_sel_next = reg_wdata_i & SCDC_WAIT_SEL_MASK;
                default: ;
            endcase
        end else if (reg_bit_wr_i) begin
            // bit writes merge one bit; wait select ignores them
            unique case (reg_addr_i)
                SCDC_ADDR_CPU_DIV:  cpu_div_next  = ((cpu_div_reg & ~bit_mask)
                                      | (reg_wdata_i & bit_mask)) & SCDC_CPU_DIV_MASK;
                SCDC_ADDR_PRESCALE: prescale_next = ((prescale_reg & ~bit_mask)
                                      | (reg_wdata_i & bit_mask)) & SCDC_PRESCALE_MASK;
                SCDC_ADDR_SLOW_OSC: slow_osc_next = ((slow_osc_reg & ~bit_mask)
                                      | (reg_wdata_i & bit_mask)) & SCDC_SLOW_OSC_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cpu_div_reg  <= SCDC_CPU_DIV_RST;
            prescale_reg <= SCDC_PRESCALE_RST;
            slow_osc_reg <= SCDC_SLOW_OSC_RST;
        end else begin
            cpu_div_reg  <= cpu_div_next;
            prescale_reg <= prescale_next;
            slow_osc_reg <= slow_osc_next;
        end
        // no reset: content undefined after reset
        wait_sel_reg <= wait_sel_next;
    end

    always_comb begin
        unique case (reg_addr_i)
            SCDC_ADDR_CPU_DIV:  reg_rdata_o = cpu_div_reg;
            SCDC_ADDR_PRESCALE: reg_rdata_o = prescale_reg;
            SCDC_ADDR_SLOW_OSC: reg_rdata_o = slow_osc_reg;
            SCDC_ADDR_WAIT_SEL: reg_rdata_o = wait_sel_reg;
            default:            reg_rdata_o = SCDC_ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // division ratios
    // ------------------------------------------------------------
    logic [2:0] cpu_exp, per_exp;
    logic       cpu_bad;
    logic       cpu_div_bit;

    assign cpu_div_bit = cpu_div_reg[SCDC_CPU_DIVIDE_POS];

    always_comb begin
        cpu_bad = 1'b0;
        unique case ({prescale_reg[1:0], cpu_div_bit})
            3'h0:    cpu_exp = SCDC_DIV_1;
            3'h2:    cpu_exp = SCDC_DIV_2;
            3'h1:    cpu_exp = SCDC_DIV_4;
            3'h4:    cpu_exp = SCDC_DIV_4;
            3'h3:    cpu_exp = SCDC_DIV_8;
            3'h5:    cpu_exp = SCDC_DIV_16;
            default: begin
                cpu_exp = SCDC_DIV_1;
                cpu_bad = 1'b1;
            end
        endcase
        unique case (prescale_reg[1:0])
            2'h1:    per_exp = SCDC_DIV_2;
            2'h2:    per_exp = SCDC_DIV_4;
            default: per_exp = SCDC_DIV_1;
        endcase
    end

    // free running divider; enables pulse once per divided period
    logic [SCDC_DIV_CNT_W-1:0] div_cnt_reg, div_cnt_next;
    logic [SCDC_DIV_CNT_W-1:0] cpu_msk, per_msk;
    logic                      cpu_en_next, per_en_next;
    logic                      cpu_en_reg, per_en_reg, cpu_bad_reg;

    always_comb begin
        div_cnt_next = div_cnt_reg + 1'b1;
        cpu_msk      = SCDC_DIV_CNT_W'((5'h01 << cpu_exp) - 5'h01);
        per_msk      = SCDC_DIV_CNT_W'((5'h01 << per_exp) - 5'h01);
        cpu_en_next  = ((div_cnt_reg & cpu_msk) == cpu_msk);
        per_en_next  = ((div_cnt_reg & per_msk) == per_msk);
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            div_cnt_reg <= '0;
            cpu_en_reg  <= 1'b0;
            per_en_reg  <= 1'b0;
            cpu_bad_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            cpu_en_reg  <= cpu_en_next;
            per_en_reg  <= per_en_next;
            cpu_bad_reg <= cpu_bad;
        end
    end

    assign cpu_clk_bad_o = cpu_bad_reg;

    // ------------------------------------------------------------
    // slow oscillator and watchdog source
    // ------------------------------------------------------------
    // option byte wins over the halt bit, so a locked watchdog can't be starved
    assign slow_osc_en_o   = !(opt_slow_stop_ok_i
                               && slow_osc_reg[SCDC_SLOW_HALT_POS]);
    assign wdt_src_fixed_o = !opt_slow_stop_ok_i;

    // ------------------------------------------------------------
    // stop mode and stabilization wait
    // ------------------------------------------------------------
    logic osc_sync1_reg, osc_sync2_reg;
    scdc_state_t state_reg, state_next;
    logic [SCDC_WAIT_CNT_W-1:0] wait_cnt_reg, wait_cnt_next, wait_len;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            osc_sync1_reg <= 1'b0;
            osc_sync2_reg <= 1'b0;
        end else begin
            osc_sync1_reg <= osc_started_i;
            osc_sync2_reg <= osc_sync1_reg;
        end
    end

    always_comb begin
        unique case (wait_sel_reg[1:0])
            2'h0: wait_len = SCDC_WAIT_CNT_W'(1 << SCDC_WAIT_EXP_0);
            2'h1: wait_len = SCDC_WAIT_CNT_W'(1 << SCDC_WAIT_EXP_1);
            2'h2: wait_len = SCDC_WAIT_CNT_W'(1 << SCDC_WAIT_EXP_2);
            2'h3: wait_len = SCDC_WAIT_CNT_W'(1 << SCDC_WAIT_EXP_3);
        endcase
    end

    always_comb begin
        state_next    = state_reg;
        wait_cnt_next = wait_cnt_reg;
        unique case (state_reg)
            SCDC_RUN:
                if (stop_exec_i) state_next = SCDC_STOPPED;
            SCDC_STOPPED:
                if (stop_release_i) begin
                    if (opt_clk_src_i == SCDC_SRC_CRYSTAL)
                        state_next = SCDC_OSC_START;
                    else
                        state_next = SCDC_RUN;
                end
            SCDC_OSC_START:
                if (osc_sync2_reg) begin
                    state_next    = SCDC_STAB_WAIT;
                    wait_cnt_next = wait_len - 1'b1;
                end
            SCDC_STAB_WAIT:
                if (wait_cnt_reg == '0) state_next = SCDC_RUN;
                else wait_cnt_next = wait_cnt_reg - 1'b1;
        endcase
    end

    // power-on source and wait are handled upstream from the option byte
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg    <= SCDC_RUN;
            wait_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    logic src_on;
    assign src_on           = (state_reg == SCDC_RUN) || (state_reg == SCDC_STAB_WAIT)
                              || (state_reg == SCDC_OSC_START);
    assign hs_int_osc_en_o  = src_on && (opt_clk_src_i == SCDC_SRC_HS_INT);
    assign crystal_osc_en_o = src_on && (opt_clk_src_i == SCDC_SRC_CRYSTAL);
    assign ext_clk_en_o     = src_on && (opt_clk_src_i == SCDC_SRC_EXT);
    assign stab_wait_o      = (state_reg == SCDC_OSC_START) || (state_reg == SCDC_STAB_WAIT);
    assign cpu_clk_en_o     = cpu_en_reg && (state_reg == SCDC_RUN);
    assign periph_clk_en_o  = per_en_reg && (state_reg == SCDC_RUN);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    cpu_div_reset_a: assert property (@(posedge sys_clk_i)
        srst_i |=> (cpu_div_reg == SCDC_CPU_DIV_RST && prescale_reg == SCDC_PRESCALE_RST))
        else $error("divider registers not 0x02 after reset");
    slow_reset_a: assert property (@(posedge sys_clk_i)
        srst_i |=> slow_osc_en_o)
        else $error("slow oscillator not running after reset");
    cpu_ratio_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (prescale_reg[1:0] == 2'h1 && cpu_div_bit) |-> cpu_exp == SCDC_DIV_8)
        else $error("cpu ratio wrong for fx/8 code");
    per_half_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (prescale_reg[1:0] == 2'h1 && $stable(prescale_reg)) |=> per_en_reg != $past(per_en_reg))
        else $error("peripheral enable not every second cycle");
    slow_lock_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !opt_slow_stop_ok_i |-> slow_osc_en_o && wdt_src_fixed_o)
        else $error("slow oscillator stopped while locked");
    wait_byte_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (reg_bit_wr_i && !reg_wr_i) |=> $stable(wait_sel_reg))
        else $error("bit write changed wait select");
    no_wait_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state_reg == SCDC_STOPPED && stop_release_i && opt_clk_src_i != SCDC_SRC_CRYSTAL)
        |=> state_reg == SCDC_RUN)
        else $error("wait inserted for non crystal source");
    osc_first_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state_reg == SCDC_OSC_START && !osc_sync2_reg) |=> state_reg == SCDC_OSC_START)
        else $error("wait began before oscillation");
    stop_halt_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        state_reg == SCDC_STOPPED |-> !(hs_int_osc_en_o || crystal_osc_en_o || ext_clk_en_o))
        else $error("source running in stop");
    bit_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (reg_bit_wr_i && !reg_wr_i && reg_addr_i == SCDC_ADDR_SLOW_OSC && reg_bit_sel_i == 3'h0)
        |=> slow_osc_reg[0] == $past(reg_wdata_i[0]))
        else $error("bit write to slow osc lost");
    unused_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (cpu_div_reg & ~SCDC_CPU_DIV_MASK) == SCDC_ZERO_BYTE)
        else $error("unused divider bit set");

endmodule

// ---- scdc_pkg.sv ----
// scdc_pkg: register map, field layout, reset values and codes for the
// system clock divider control block.
// assumes: 8-bit cpu register port, 16-bit addresses.
package scdc_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] SCDC_ADDR_SLOW_OSC   = 16'hFF58;
    localparam logic [15:0] SCDC_ADDR_PRESCALE   = 16'hFFF3;
    localparam logic [15:0] SCDC_ADDR_WAIT_SEL   = 16'hFFF4;
    localparam logic [15:0] SCDC_ADDR_CPU_DIV    = 16'hFFFB;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          SCDC_CPU_DIVIDE_POS  = 1;
    localparam int          SCDC_SLOW_HALT_POS   = 0;
    localparam logic [7:0]  SCDC_CPU_DIV_RST     = 8'h02;
    localparam logic [7:0]  SCDC_PRESCALE_RST    = 8'h02;
    localparam logic [7:0]  SCDC_SLOW_OSC_RST    = 8'h00;
    localparam logic [7:0]  SCDC_CPU_DIV_MASK    = 8'h02;
    localparam logic [7:0]  SCDC_PRESCALE_MASK   = 8'h03;
    localparam logic [7:0]  SCDC_SLOW_OSC_MASK   = 8'h01;
    localparam logic [7:0]  SCDC_WAIT_SEL_MASK   = 8'h03;
    localparam logic [7:0]  SCDC_ZERO_BYTE       = 8'h00;

    // ----------------------------------------------------------------
    // division exponents of the system clock
    // ----------------------------------------------------------------
    localparam logic [2:0]  SCDC_DIV_1           = 3'h0;
    localparam logic [2:0]  SCDC_DIV_2           = 3'h1;
    localparam logic [2:0]  SCDC_DIV_4           = 3'h2;
    localparam logic [2:0]  SCDC_DIV_8           = 3'h3;
    localparam logic [2:0]  SCDC_DIV_16          = 3'h4;
    localparam int          SCDC_DIV_CNT_W       = 4;

    // ----------------------------------------------------------------
    // stabilization wait exponents (system clock periods = 2**exp)
    // ----------------------------------------------------------------
    localparam int          SCDC_WAIT_EXP_0      = 10;
    localparam int          SCDC_WAIT_EXP_1      = 12;
    localparam int          SCDC_WAIT_EXP_2      = 15;
    localparam int          SCDC_WAIT_EXP_3      = 17;
    localparam int          SCDC_WAIT_CNT_W      = 18;

    // system clock source codes from the option byte
    localparam logic [1:0]  SCDC_SRC_HS_INT      = 2'h0;
    localparam logic [1:0]  SCDC_SRC_CRYSTAL     = 2'h1;
    localparam logic [1:0]  SCDC_SRC_EXT         = 2'h2;

    typedef enum logic [1:0] {
        SCDC_RUN,
        SCDC_STOPPED,
        SCDC_OSC_START,
        SCDC_STAB_WAIT
    } scdc_state_t;

endpackage

// ---- tb_scdc_clock_ctrl.sv ----
// tb_scdc_clock_ctrl: self-checking bench for the clock divider control block.
// assumes: scdc_pkg and scdc_clock_ctrl compiled first; bench drives all ports.
`timescale 1ns/10ps
module tb_scdc_clock_ctrl import scdc_pkg::*;;
    logic        sys_clk_i, srst_i, reg_wr_i, reg_bit_wr_i;
    logic [15:0] reg_addr_i;
    logic [2:0]  reg_bit_sel_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o;
    logic [1:0]  opt_clk_src_i;
    logic        opt_slow_stop_ok_i, stop_exec_i, stop_release_i, osc_started_i;
    logic        cpu_clk_en_o, periph_clk_en_o, cpu_clk_bad_o, hs_int_osc_en_o;
    logic        crystal_osc_en_o, ext_clk_en_o, slow_osc_en_o, wdt_src_fixed_o;
    logic        stab_wait_o;
    int          fails, check_count, seed, mdl[4], c, p, n;
    logic [15:0] addrs[4] = '{SCDC_ADDR_SLOW_OSC, SCDC_ADDR_PRESCALE,
                              SCDC_ADDR_WAIT_SEL, SCDC_ADDR_CPU_DIV};
    logic [7:0]  masks[4] = '{SCDC_SLOW_OSC_MASK, SCDC_PRESCALE_MASK,
                              SCDC_WAIT_SEL_MASK, SCDC_CPU_DIV_MASK};
    int          wexp[4]  = '{SCDC_WAIT_EXP_0, SCDC_WAIT_EXP_1,
                              SCDC_WAIT_EXP_2, SCDC_WAIT_EXP_3};

    scdc_clock_ctrl i_dut (
        .sys_clk_i          (sys_clk_i),
        .srst_i             (srst_i),
        .reg_addr_i         (reg_addr_i),
        .reg_wr_i           (reg_wr_i),
        .reg_bit_wr_i       (reg_bit_wr_i),
        .reg_bit_sel_i      (reg_bit_sel_i),
        .reg_wdata_i        (reg_wdata_i),
        .reg_rdata_o        (reg_rdata_o),
        .opt_clk_src_i      (opt_clk_src_i),
        .opt_slow_stop_ok_i (opt_slow_stop_ok_i),
        .stop_exec_i        (stop_exec_i),
        .stop_release_i     (stop_release_i),
        .osc_started_i      (osc_started_i),
        .cpu_clk_en_o       (cpu_clk_en_o),
        .periph_clk_en_o    (periph_clk_en_o),
        .cpu_clk_bad_o      (cpu_clk_bad_o),
        .hs_int_osc_en_o    (hs_int_osc_en_o),
        .crystal_osc_en_o   (crystal_osc_en_o),
        .ext_clk_en_o       (ext_clk_en_o),
        .slow_osc_en_o      (slow_osc_en_o),
        .wdt_src_fixed_o    (wdt_src_fixed_o),
        .stab_wait_o        (stab_wait_o)
    );

    // ------------------------------------------------------------
    // clock, watchdog, verdict
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #(40000 * 50);
        fails++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // register port and model
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = addrs[i];
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
        mdl[i] = d & masks[i];
    endtask
    // wait select ignores bit writes, so its model stays put
    task automatic bwr(input int i, input logic [2:0] b, input logic v);
        @(negedge sys_clk_i);
        reg_addr_i = addrs[i];
        reg_bit_sel_i = b;
        reg_wdata_i = {8{v}};
        reg_bit_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_bit_wr_i = 1'b0;
        if (i != 2) mdl[i] = ((mdl[i] & ~(1 << b)) | (v << b)) & masks[i];
    endtask
    task automatic rd(input int i);
        @(negedge sys_clk_i);
        reg_addr_i = addrs[i];
        #1 chk(reg_rdata_o, mdl[i]);
    endtask
    function automatic int cpu_div(input int code);
        case (code)
            0: return 1;
            2: return 2;
            1, 4: return 4;
            3: return 8;
            5: return 16;
            default: return 1;
        endcase
    endfunction
    task automatic count_en();
        c = 0;
        p = 0;
        repeat (64) begin
            @(negedge sys_clk_i);
            c += cpu_clk_en_o;
            p += periph_clk_en_o;
        end
    endtask
    task automatic chk_src(input int s);
        chk({hs_int_osc_en_o, crystal_osc_en_o, ext_clk_en_o}, 3'h4 >> s);
    endtask
    // one stop and release pass; crystal waits for the started level
    task automatic stop_cycle(input logic [1:0] s, input int ws);
        opt_clk_src_i = s;
        wr(2, ws);
        chk_src(s);
        @(negedge sys_clk_i) stop_exec_i = 1'b1;
        @(negedge sys_clk_i) stop_exec_i = 1'b0;
        chk({hs_int_osc_en_o, crystal_osc_en_o, ext_clk_en_o}, 3'h0);
        repeat (3) @(negedge sys_clk_i);
        stop_release_i = 1'b1;
        @(negedge sys_clk_i) stop_release_i = 1'b0;
        if (s != SCDC_SRC_CRYSTAL) begin
            @(negedge sys_clk_i);
            chk(stab_wait_o, 1'b0);
        end else begin
            repeat (50) @(negedge sys_clk_i);
            chk(stab_wait_o, 1'b1);
            osc_started_i = 1'b1;
            n = 0;
            while (stab_wait_o !== 1'b0 && n < 200000) begin
                @(negedge sys_clk_i);
                n++;
            end
            chk(n >= 2**wexp[ws] && n <= 2**wexp[ws] + 4, 1'b1);
            osc_started_i = 1'b0;
        end
        chk_src(s);
        $display("test stop source %0d wait %0d done", s, ws);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 48284;
        {srst_i, reg_wr_i, reg_bit_wr_i, reg_bit_sel_i, reg_wdata_i} = '0;
        {stop_exec_i, stop_release_i, osc_started_i, opt_clk_src_i} = '0;
        reg_addr_i = SCDC_ADDR_CPU_DIV;
        opt_slow_stop_ok_i = 1'b1;
        srst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i) srst_i = 1'b0;
        mdl = '{0, 2, 0, 2};
        rd(0);
        rd(1);
        rd(3);
        chk(slow_osc_en_o, 1'b1);
        $display("test reset values done");
        // every cpu code, including the prohibited ones
        for (int k = 0; k < 8; k++) begin
            wr(1, k >> 1);
            wr(3, (k & 1) << 1);
            repeat (20) @(negedge sys_clk_i);
            count_en();
            chk(c, 64 / cpu_div(k));
            chk(cpu_clk_bad_o, k >= 6);
            if ((k >> 1) == 1) chk(p, 32);
            if ((k >> 1) == 2) chk(p, 16);
        end
        $display("test divider codes done");
        wr(2, 8'h00);
        for (int k = 0; k < 40; k++) begin
            n = $unsigned($random(seed)) % 4;
            if (k[0]) wr(n, $random(seed));
            else bwr(n, $random(seed), $random(seed));
            rd(n);
        end
        wr(2, 8'hFF);
        bwr(2, 3'h1, 1'b0);
        rd(2);
        $display("test register access done");
        opt_slow_stop_ok_i = 1'b1;
        wr(0, 8'hFF);
        chk(slow_osc_en_o, 1'b0);
        chk(wdt_src_fixed_o, 1'b0);
        @(negedge sys_clk_i) opt_slow_stop_ok_i = 1'b0;
        #1 chk(slow_osc_en_o, 1'b1);
        chk(wdt_src_fixed_o, 1'b1);
        opt_slow_stop_ok_i = 1'b1;
        bwr(0, 3'h0, 1'b0);
        chk(slow_osc_en_o, 1'b1);
        $display("test slow oscillator done");
        stop_cycle(SCDC_SRC_HS_INT, 0);
        stop_cycle(SCDC_SRC_EXT, 3);
        stop_cycle(SCDC_SRC_CRYSTAL, 0);
        stop_cycle(SCDC_SRC_CRYSTAL, 1);
        // mid-run reset must restore written registers
        wr(1, 8'h01);
        wr(3, 8'h00);
        wr(0, 8'h01);
        @(negedge sys_clk_i) srst_i = 1'b1;
        @(negedge sys_clk_i) srst_i = 1'b0;
        mdl[0] = 0;
        mdl[1] = 2;
        mdl[3] = 2;
        rd(0);
        rd(1);
        rd(3);
        chk(slow_osc_en_o, 1'b1);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
